// [hdl/anm_match.sv]
// config word matching and arbitration for the auto-negotiation receiver
`timescale 1ns/1ns
// Functional notes
// [RL1] both ends exchange a 16-bit ability word; the received word that produced ability match is kept
// [RL2] no ACK transmitted when the matched received word is all zero
// [RL3] any consistent non-zero word, reserved ones too, leads to ACK
// [RL4] ability match ignores bit 14; any other differing bit breaks the match
// [RL5] ACK only after three identical consecutive words, never after one or two
// [RL6] a received idle set restarts the consecutive-word count
// [RL7] a word differing from the run's first restarts the count at one
// [RL8] acknowledge match needs three identical consecutive words with bit 14 set
// [RL9] go to complete-acknowledge only if acked word equals the ability word
// [RL10] inconsistent ACK-set words never reach complete-acknowledge
// [RL11] in complete-acknowledge keep sending word with ACK for link timer
// [RL12] after link timer expiry send idle or a next page
// [RL13] consistency compares ability-matched and ack-matched words ignoring bit 14
// [RL14] a consistency failure restarts auto-negotiation
// [RL15] entering acknowledge-detect sets the transmitted ACK bit
// [RL16] counters step once per received set and clear on restart
module anm_match
	import anm_pkg::*;
#(
	parameter int unsigned LINK_TIMER_CYC = ANM_LINK_TIMER_CYC
) (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	// control from management
	input wire logic i_an_restart,
	input wire logic [15:0] i_local_cfg,
	input wire logic i_next_page,
	// received ordered sets
	input wire anm_rx_t i_rx,
	// transmit request and status
	output anm_tx_t o_tx,
	output logic o_ability_match,
	output logic o_ack_match,
	output logic o_consist_fail,
	output anm_state_t o_state
);

	// arbitration state
	anm_state_t state_q;
	anm_state_t state_d;

	// ability run: first word of the run and how many matched it
	logic [15:0] ab_first_q;
	logic [15:0] ab_first_d;
	logic [1:0] ab_cnt_q;
	logic [1:0] ab_cnt_d;

	// ack run: exact words with the ack bit set
	logic [15:0] ak_first_q;
	logic [15:0] ak_first_d;
	logic [1:0] ak_cnt_q;
	logic [1:0] ak_cnt_d;

	// word that won ability match, kept for the consistency check
	logic [15:0] ab_word_q;
	logic [15:0] ab_word_d;

	// link timer, wide enough for any sensible timer setting
	logic [31:0] timer_q;
	logic timer_done;

	// decoded match results
	logic ability_match;
	logic ack_match;
	logic consistent;
	logic restart;
	logic clear_runs;

	// outputs
	anm_tx_t tx_q;
	anm_tx_t tx_d;
	logic fail_q;

	// masked compare: the ack bit is the only bit allowed to differ
	function automatic logic same_no_ack(input logic [15:0] a, input logic [15:0] b);
		logic [15:0] am;
		logic [15:0] bm;
		am = a & ANM_ACK_MASK;
		bm = b & ANM_ACK_MASK;
		same_no_ack = (am == bm);
	endfunction : same_no_ack

	// saturating step so a long steady run never wraps back below three
	function automatic logic [1:0] bump(input logic [1:0] c);
		if (c == ANM_MATCH_CNT) begin
			bump = c;
		end else begin
			bump = c + 2'h1;
		end
	endfunction : bump

	assign restart = i_an_restart || (state_q == ANM_ST_RESTART);
	// sets arriving during restart are dropped, so no stale run survives it
	assign clear_runs = restart || i_rx.idle_valid;

	// [RL4] ability run counter
	// [RL6] idle clears run
	// [RL16] one step per set
	always_comb begin
		ab_cnt_d = ab_cnt_q;
		ab_first_d = ab_first_q;
		if (clear_runs) begin
			ab_cnt_d = ANM_CNT_RST;
			ab_first_d = ANM_CFG_RST;
		end else if (i_rx.cfg_valid) begin
			// [RL7] mismatch starts new run
			if (ab_cnt_q != ANM_CNT_RST && same_no_ack(ab_first_q, i_rx.cfg_word)) begin
				ab_cnt_d = bump(ab_cnt_q);
			end else begin
				ab_cnt_d = 2'h1;
				ab_first_d = i_rx.cfg_word;
			end
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			ab_cnt_q <= ANM_CNT_RST;
			ab_first_q <= ANM_CFG_RST;
		end else begin
			ab_cnt_q <= ab_cnt_d;
			ab_first_q <= ab_first_d;
		end
	end

	// [RL8] ack run counter, exact match with ack set
	always_comb begin
		ak_cnt_d = ak_cnt_q;
		ak_first_d = ak_first_q;
		if (clear_runs) begin
			ak_cnt_d = ANM_CNT_RST;
			ak_first_d = ANM_CFG_RST;
		end else if (i_rx.cfg_valid) begin
			if (!i_rx.cfg_word[ANM_ACK_BIT]) begin
				ak_cnt_d = ANM_CNT_RST;
			end else if (ak_cnt_q != ANM_CNT_RST && ak_first_q == i_rx.cfg_word) begin
				ak_cnt_d = bump(ak_cnt_q);
			end else begin
				ak_cnt_d = 2'h1;
				ak_first_d = i_rx.cfg_word;
			end
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			ak_cnt_q <= ANM_CNT_RST;
			ak_first_q <= ANM_CFG_RST;
		end else begin
			ak_cnt_q <= ak_cnt_d;
			ak_first_q <= ak_first_d;
		end
	end

	// [RL5] three words needed
	assign ability_match = (ab_cnt_q == ANM_MATCH_CNT);
	assign ack_match = (ak_cnt_q == ANM_MATCH_CNT);
	// [RL13] compare captured words
	assign consistent = same_no_ack(ab_word_q, ak_first_q);

	// [RL1] hold the word that produced ability match
	always_comb begin
		ab_word_d = ab_word_q;
		if (restart) begin
			ab_word_d = ANM_CFG_RST;
		end else if (state_q == ANM_ST_ABILITY && ability_match) begin
			ab_word_d = ab_first_q;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			ab_word_q <= ANM_CFG_RST;
		end else begin
			ab_word_q <= ab_word_d;
		end
	end

	always_comb begin
		state_d = state_q;
		case (state_q)
			ANM_ST_RESTART: begin
				state_d = ANM_ST_ABILITY;
			end
			ANM_ST_ABILITY: begin
				// [RL2] zero word never acked
				// [RL3] any non-zero word acked
				if (ability_match && ab_first_q != ANM_CFG_RST) begin
					state_d = ANM_ST_ACK_DET;
				end
			end
			ANM_ST_ACK_DET: begin
				// [RL9] acked word must match
				// [RL10] inconsistent words block
				// [RL14] failure restarts
				if (ack_match && consistent) begin
					state_d = ANM_ST_CMPL_ACK;
				end else if (ack_match) begin
					state_d = ANM_ST_RESTART;
				end
			end
			ANM_ST_CMPL_ACK: begin
				// [RL12] timer expiry ends acking
				if (timer_done) begin
					state_d = ANM_ST_IDLE_OUT;
				end
			end
			ANM_ST_IDLE_OUT: begin
				state_d = ANM_ST_IDLE_OUT;
			end
			default: begin
				state_d = ANM_ST_RESTART;
			end
		endcase
		if (i_an_restart) begin
			state_d = ANM_ST_RESTART;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			state_q <= ANM_ST_RESTART;
		end else begin
			state_q <= state_d;
		end
	end

	// expiry flagged one count early so the state stays exactly the timer span
	assign timer_done = (timer_q >= LINK_TIMER_CYC - 1);

	// [RL11] link timer runs in complete-acknowledge only
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n || state_q != ANM_ST_CMPL_ACK) begin
			timer_q <= 32'h0;
		end else begin
			timer_q <= timer_q + 32'h1;
		end
	end

	// consistency failure flag, one cycle per failed acknowledgement
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			fail_q <= 1'b0;
		end else begin
			fail_q <= (state_q == ANM_ST_ACK_DET) && ack_match && !consistent;
		end
	end

	// [RL15] ack bit from acknowledge-detect onward
	// [RL11] ack kept through complete-acknowledge
	// [RL12] then idle, or a next page if one is pending
	// built from the next state so the word changes on the same edge as the state
	always_comb begin
		tx_d = '0;
		case (state_d)
			ANM_ST_RESTART: begin
				tx_d.send_cfg = 1'b1;
				tx_d.send_idle = 1'b0;
				tx_d.cfg_word = ANM_CFG_RST;
			end
			ANM_ST_ABILITY: begin
				tx_d.send_cfg = 1'b1;
				tx_d.send_idle = 1'b0;
				tx_d.cfg_word = i_local_cfg & ANM_ACK_MASK;
			end
			ANM_ST_ACK_DET, ANM_ST_CMPL_ACK: begin
				tx_d.send_cfg = 1'b1;
				tx_d.send_idle = 1'b0;
				tx_d.cfg_word = i_local_cfg | ~ANM_ACK_MASK;
			end
			ANM_ST_IDLE_OUT: begin
				// next page content is supplied by the page logic on i_local_cfg
				if (i_next_page) begin
					tx_d.send_cfg = 1'b1;
					tx_d.send_idle = 1'b0;
					tx_d.cfg_word = i_local_cfg & ANM_ACK_MASK;
				end else begin
					tx_d.send_cfg = 1'b0;
					tx_d.send_idle = 1'b1;
					tx_d.cfg_word = ANM_CFG_RST;
				end
			end
			default: begin
				tx_d = '0;
			end
		endcase
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			tx_q <= '0;
		end else begin
			tx_q <= tx_d;
		end
	end

	assign o_tx = tx_q;
	assign o_ability_match = ability_match;
	assign o_ack_match = ack_match;
	assign o_consist_fail = fail_q;
	assign o_state = state_q;

endmodule : anm_match

// [hdl/anm_pkg.sv]
// package for the auto-negotiation config match block
package anm_pkg;
	localparam int unsigned ANM_CFG_W = 16;
	localparam int unsigned ANM_ACK_BIT = 14;
	localparam logic [1:0] ANM_MATCH_CNT = 2'h3;
	localparam logic [15:0] ANM_CFG_RST = 16'h0000;
	localparam logic [1:0] ANM_CNT_RST = 2'h0;
	localparam int unsigned ANM_CLK_MHZ = 100;
	localparam int unsigned ANM_LINK_TIMER_US = 10;
	localparam int unsigned ANM_LINK_TIMER_CYC = ANM_LINK_TIMER_US * ANM_CLK_MHZ;
	localparam logic [15:0] ANM_ACK_MASK = 16'hbfff;

	typedef enum logic [2:0] {
		ANM_ST_RESTART = 3'b000,
		ANM_ST_ABILITY = 3'b001,
		ANM_ST_ACK_DET = 3'b010,
		ANM_ST_CMPL_ACK = 3'b011,
		ANM_ST_IDLE_OUT = 3'b100
	} anm_state_t;

	// one received ordered set: /C/ with its word, or /I/
	typedef struct packed {
		logic cfg_valid;
		logic idle_valid;
		logic [15:0] cfg_word;
	} anm_rx_t;

	// transmit request toward the encoder
	typedef struct packed {
		logic send_cfg;
		logic send_idle;
		logic [15:0] cfg_word;
	} anm_tx_t;
endpackage : anm_pkg

// [testbench/anm_match_assertions.sv]
// checker for the config match block ports
`timescale 1ns/1ns
module anm_chk
	import anm_pkg::*;
#(parameter int unsigned LINK_TIMER_CYC = 20) (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_an_restart,
	input wire logic [15:0] i_local_cfg,
	input wire logic i_next_page,
	input wire anm_rx_t i_rx,
	input wire anm_tx_t o_tx,
	input wire logic o_ability_match,
	input wire logic o_ack_match,
	input wire logic o_consist_fail,
	input wire anm_state_t o_state
);
	logic [15:0] cnt_q;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	// cycles spent in complete-acknowledge, for the timer figure
	always_ff @(posedge i_clk_sys) cnt_q <= (o_state == ANM_ST_CMPL_ACK) ? cnt_q + 16'h1 : 16'h0;
	sequence s_abil(logic z);
		o_state == ANM_ST_ABILITY && o_ability_match && !i_an_restart && $past(i_rx.cfg_valid)
			&& (($past(i_rx.cfg_word) == 16'h0) == z);
	endsequence
	sequence s_ack_hit;
		o_state == ANM_ST_ACK_DET && o_ack_match && !i_an_restart;
	endsequence
	zero_stay_a: assert property (s_abil(1'b1) |=> o_state == ANM_ST_ABILITY)
		else $error("zero word left ability state");
	ack_enter_a: assert property (s_abil(1'b0) |=> o_state == ANM_ST_ACK_DET
		&& o_tx.cfg_word == (i_local_cfg | 16'h4000)) else $error("no ack after match");
	// back-to-back sets assumed, as the partner sends them
	abil_three_a: assert property ($rose(o_ability_match) |-> $past(i_rx.cfg_valid, 3)
		&& $past(i_rx.cfg_valid, 2) && (($past(i_rx.cfg_word, 3) ^ $past(i_rx.cfg_word)) & ANM_ACK_MASK)
		== 16'h0) else $error("ability match too early");
	ack_three_a: assert property ($rose(o_ack_match) |-> $past(i_rx.cfg_word[14])
		&& $past(i_rx.cfg_word, 3) == $past(i_rx.cfg_word)) else $error("ack match too early");
	idle_clear_a: assert property ($past(i_rx.idle_valid) |-> !o_ability_match && !o_ack_match)
		else $error("idle kept a count");
	restart_a: assert property (i_an_restart |=> o_state == ANM_ST_RESTART
		&& o_tx.cfg_word == 16'h0) else $error("restart ignored");
	consist_a: assert property (s_ack_hit |=> o_consist_fail != (o_state == ANM_ST_CMPL_ACK))
		else $error("ack outcome wrong");
	fail_rst_a: assert property (o_consist_fail |-> o_state == ANM_ST_RESTART)
		else $error("fail without restart");
	hold_ack_a: assert property (o_state == ANM_ST_CMPL_ACK |-> o_tx.send_cfg
		&& o_tx.cfg_word == (i_local_cfg | 16'h4000)) else $error("ack word dropped");
	timer_end_a: assert property (o_state == ANM_ST_IDLE_OUT && $past(o_state) == ANM_ST_CMPL_ACK
		|-> cnt_q == LINK_TIMER_CYC && o_tx.send_idle == !i_next_page) else $error("timer end wrong");
endmodule : anm_chk
bind anm_match anm_chk #(.LINK_TIMER_CYC(LINK_TIMER_CYC)) anm_chk_inst (.i_clk_sys, .i_rst_n,
	.i_an_restart, .i_local_cfg, .i_next_page, .i_rx, .o_tx, .o_ability_match, .o_ack_match,
	.o_consist_fail, .o_state);

// [testbench/anm_partner.sv]
// link partner model sending one ordered set per call
`timescale 1ns/1ns
module anm_partner
	import anm_pkg::*;
(
	input wire logic i_clk_sys,
	output anm_rx_t o_rx
);
	initial o_rx = '0;
	// whole word per set
	// k: bit0 config set, bit1 idle set; a gap shows the inverted word, not the last one
	task automatic put(input logic [15:0] w, input logic [1:0] k);
		@(posedge i_clk_sys);
		o_rx <= {k[0], k[1], k[0] ? w : ~o_rx.cfg_word};
	endtask : put
endmodule : anm_partner

// [testbench/anm_match_bench.sv]
// self-checking bench for the config match block
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
	$display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module anm_match_bench import anm_pkg::*; ;
	localparam int unsigned LT = 20;
	logic i_clk_sys = 1'b0;
	logic i_rst_n = 1'b0;
	logic i_an_restart = 1'b0;
	logic [15:0] i_local_cfg = 16'h0;
	logic i_next_page = 1'b0;
	anm_rx_t i_rx;
	anm_tx_t o_tx;
	logic o_ability_match, o_ack_match, o_consist_fail;
	anm_state_t o_state, prev_s;
	anm_state_t exp_q[$];
	logic [2:0] e_s;
	logic [15:0] w, a;
	int num_errors = 0;
	int n_compared = 0;
	int seed = 32'hae7d1428;
	always #5 i_clk_sys = ~i_clk_sys;
	anm_match #(.LINK_TIMER_CYC(LT)) anm_match_inst (.i_clk_sys, .i_rst_n, .i_an_restart,
		.i_local_cfg, .i_next_page, .i_rx, .o_tx, .o_ability_match, .o_ack_match,
		.o_consist_fail, .o_state);
	anm_partner anm_partner_inst (.i_clk_sys, .o_rx(i_rx));
	task automatic sq(input logic [15:0] v, input int n, input logic [1:0] k);
		repeat (n) anm_partner_inst.put(v, k);
	endtask : sq
	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : tally_and_finish
	// every state step is taken against the oldest note
	always @(negedge i_clk_sys) begin
		if (i_rst_n && o_state !== prev_s) begin
			e_s = exp_q.size() != 0 ? exp_q.pop_front() : 3'h7;
			`CHK("state", e_s, o_state)
		end
		prev_s = o_state;
	end
	// run is about 140 cycles; far past that means a hang
	initial begin
		repeat (5000) @(posedge i_clk_sys);
		num_errors++;
		tally_and_finish();
	end
	initial begin
		repeat (12) @(posedge i_clk_sys);
		i_local_cfg <= $random(seed);
		i_rst_n <= 1'b1;
		exp_q.push_back(ANM_ST_ABILITY);
		repeat (2) @(posedge i_clk_sys);
		for (int np = 0; np < 2; np++) begin
			w = $random(seed) & 16'hbffe | 16'h1;
			a = w | 16'h4000;
			i_next_page <= np[0];
			sq(16'h0, 4, 2'h1);
			sq(w, 2, 2'h1);
			sq(w, 1, 2'h2);
			sq(w, 2, 2'h1);
			sq(w ^ 16'h2, 1, 2'h1);
			sq(w, 2, 2'h1);
			exp_q.push_back(ANM_ST_ACK_DET);
			sq(w, 1, 2'h1);
			sq(a, 2, 2'h1);
			sq(a, 1, 2'h2);
			sq(a, 2, 2'h1);
			sq(a ^ 16'h1, 1, 2'h1);
			sq(a, 2, 2'h1);
			sq(w, 1, 2'h1);
			exp_q.push_back(ANM_ST_CMPL_ACK);
			exp_q.push_back(ANM_ST_IDLE_OUT);
			sq(a, 3, 2'h1);
			sq(a, LT + 4, 2'h2);
			`CHK("send_idle", !np[0], o_tx.send_idle)
			`CHK("tx_word", np[0] ? i_local_cfg & 16'hbfff : 16'h0, o_tx.cfg_word)
			sq(a, 1, 2'h0);
			exp_q.push_back(ANM_ST_RESTART);
			exp_q.push_back(ANM_ST_ABILITY);
			i_an_restart <= 1'b1;
			@(posedge i_clk_sys);
			i_an_restart <= 1'b0;
			sq(a, 3, 2'h0);
			exp_q.push_back(ANM_ST_ACK_DET);
			sq(w, 3, 2'h1);
			exp_q.push_back(ANM_ST_RESTART);
			exp_q.push_back(ANM_ST_ABILITY);
			sq(a ^ 16'h0100, 3, 2'h1);
			sq(a, 4, 2'h0);
		end
		`CHK("notes left", 0, exp_q.size())
		tally_and_finish();
	end
endmodule : anm_match_bench
